//--- hw/oscrc_top.v
// Oscillator control status bits and reference clock output
`timescale 1ns/10ps
`include "oscrc_consts.vh"

module oscrc_top (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // Register port
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWrStb,
    input  wire        regRdStb,
    output reg  [15:0] regRdData_ff,
    // Configuration words
    input  wire [2:0]  initialOscConfig,
    input  wire        clockMonitorConfigBit,
    input  wire        secondaryOscSourceConfig,
    // Oscillator analog side, asynchronous
    input  wire        primaryOscClk,
    input  wire        pllLockRaw,
    input  wire        pllTimerDone,
    input  wire        clockFailDetect,
    input  wire        switchDone,
    // Power state, same clock
    input  wire        sleepMode,
    input  wire        pllModeActive,
    // Oscillator controls
    output reg         secondaryOscOn_ff,
    output reg         secondaryOscHighPower_ff,
    output reg         oscSwitchStart_ff,
    output reg  [2:0]  nextOscSelect_ff,
    // Reference clock pin
    output reg         refclkOutputPin_ff,
    output reg         refclkOutputPinOe_ff,
    // Interrupt
    output reg         irq_ff
);
    // ----------------------------------------------------------------
    // Control and status state
    // ----------------------------------------------------------------
    reg        clockSelectLock_ff;
    reg        pllLockedFlag_ff;
    reg        clockFailFlag_ff;
    reg        secondaryOscHighDrive_ff;
    reg        secondaryOscEnable_ff;
    reg        oscSwitchRequest_ff;
    reg        cfgLoaded_ff;
    reg [15:0] refclkControl_ff;
    reg [2:0]  irqStatus_ff;
    reg [2:0]  irqMask_ff;
    reg        switchDoneDly_ff;
    reg        primLevelDly_ff;
    reg        sysTick_ff;
    reg        nxt_pllLocked;
    reg        nxt_switchReq;
    reg [15:0] nxt_rdData;
    reg [2:0]  nxt_irqStatus;

    wire [4:0] syncIn;
    wire       primLevel;
    wire       pllLockSync;
    wire       pllTimerSync;
    wire       clockFailSync;
    wire       switchDoneSync;
    wire       switchDonePulse;
    wire       primTick;
    wire       baseTick;
    wire       refRun;
    wire       refDivOut;
    wire       lockActive;
    wire       wrOsc;
    wire       wrRef;
    wire       wrStat;
    wire       wrMask;
    wire [15:0] oscControlView;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    oscrc_sync #(
        .WIDTH (5)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn ({primaryOscClk, pllLockRaw, pllTimerDone, clockFailDetect, switchDone}),
        .syncOut (syncIn)
    );

    assign primLevel      = syncIn[4];
    assign pllLockSync    = syncIn[3];
    assign pllTimerSync   = syncIn[2];
    assign clockFailSync  = syncIn[1];
    assign switchDoneSync = syncIn[0];

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            switchDoneDly_ff <= 1'b0;
            primLevelDly_ff  <= 1'b0;
            sysTick_ff       <= 1'b0;
        end else begin
            switchDoneDly_ff <= switchDoneSync;
            primLevelDly_ff  <= primLevel;
            sysTick_ff       <= 1'b1;
        end
    end

    assign switchDonePulse = switchDoneSync & ~switchDoneDly_ff;
    // Primary oscillator is sampled, so it must run below half of ref_clk
    assign primTick = primLevel ^ primLevelDly_ff;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function is_addr;
        input [3:0] addr;
        input [3:0] target;
        begin
            is_addr = (addr == target);
        end
    endfunction

    assign wrOsc  = regWrStb & is_addr(regAddr, `OSCRC_ADDR_OSC_CTRL);
    assign wrRef  = regWrStb & is_addr(regAddr, `OSCRC_ADDR_REFCLK_CTRL);
    assign wrStat = regWrStb & is_addr(regAddr, `OSCRC_ADDR_IRQ_STATUS);
    assign wrMask = regWrStb & is_addr(regAddr, `OSCRC_ADDR_IRQ_MASK);

    // ----------------------------------------------------------------
    // Oscillator control register
    // ----------------------------------------------------------------
    // Lock only counts while the failsafe monitor is configured on
    assign lockActive = clockMonitorConfigBit & clockSelectLock_ff;

    always @* begin
        nxt_switchReq = oscSwitchRequest_ff;
        if (switchDonePulse) begin
            nxt_switchReq = 1'b0;
        end else if (wrOsc && regWrData[`OSCRC_OSC_SWITCH_BIT] && !lockActive) begin
            nxt_switchReq = 1'b1;
        end
    end

    always @* begin
        nxt_pllLocked = pllLockSync | pllTimerSync;
        if (oscSwitchRequest_ff || !pllModeActive) begin
            nxt_pllLocked = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            clockSelectLock_ff       <= 1'b0;
            pllLockedFlag_ff         <= 1'b0;
            clockFailFlag_ff         <= 1'b0;
            secondaryOscHighDrive_ff <= 1'b0;
            secondaryOscEnable_ff    <= 1'b0;
            oscSwitchRequest_ff      <= 1'b0;
            nextOscSelect_ff         <= 3'h0;
            cfgLoaded_ff             <= 1'b0;
        end else begin
            oscSwitchRequest_ff <= nxt_switchReq;
            pllLockedFlag_ff    <= nxt_pllLocked;
            // Failure is sticky until reset: a clock loss must not vanish
            if (clockFailSync) begin
                clockFailFlag_ff <= 1'b1;
            end
            if (!cfgLoaded_ff) begin
                // Configuration strap caught at the first edge after release
                cfgLoaded_ff     <= 1'b1;
                nextOscSelect_ff <= initialOscConfig;
            end else if (wrOsc) begin
                clockSelectLock_ff       <= regWrData[`OSCRC_CLK_LOCK_BIT];
                secondaryOscHighDrive_ff <= regWrData[`OSCRC_SECONDARY_OSCILLATOR_DRV_BIT];
                secondaryOscEnable_ff    <= regWrData[`OSCRC_SECONDARY_OSCILLATOR_EN_BIT];
                if (!lockActive) begin
                    nextOscSelect_ff <= regWrData[`OSCRC_NEXT_OSC_MSB:`OSCRC_NEXT_OSC_LSB];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Secondary oscillator and switch start controls
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            secondaryOscOn_ff        <= 1'b0;
            secondaryOscHighPower_ff <= 1'b0;
            oscSwitchStart_ff        <= 1'b0;
        end else begin
            secondaryOscOn_ff <= secondaryOscEnable_ff;
            // Digital clock input has no drive stage at all
            secondaryOscHighPower_ff <= secondaryOscSourceConfig & secondaryOscHighDrive_ff;
            oscSwitchStart_ff <= oscSwitchRequest_ff;
        end
    end

    // ----------------------------------------------------------------
    // Reference clock control and output
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            refclkControl_ff <= `OSCRC_REFCLK_RESET;
        end else if (wrRef) begin
            refclkControl_ff <= regWrData & 16'hbf00;
        end
    end

    // Primary source assumes software enabled the crystal
    assign baseTick = refclkControl_ff[`OSCRC_REF_SRC_BIT] ? primTick : sysTick_ff;
    assign refRun   = refclkControl_ff[`OSCRC_REF_EN_BIT] &
                      (~sleepMode | refclkControl_ff[`OSCRC_REF_SLP_BIT]);

    oscrc_refdiv u_refdiv (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .runEn     (refRun),
        .baseTick  (baseTick),
        .divSel    (refclkControl_ff[`OSCRC_REF_DIV_MSB:`OSCRC_REF_DIV_LSB]),
        .refOut_ff (refDivOut)
    );

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            refclkOutputPin_ff   <= 1'b0;
            refclkOutputPinOe_ff <= 1'b0;
        end else begin
            refclkOutputPin_ff   <= refDivOut;
            refclkOutputPinOe_ff <= refclkControl_ff[`OSCRC_REF_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always @* begin
        nxt_irqStatus = irqStatus_ff;
        if (wrStat) begin
            nxt_irqStatus = nxt_irqStatus & ~regWrData[2:0];
        end
        // Set wins over a clear in the same cycle
        nxt_irqStatus[`OSCRC_IRQ_FAIL_BIT]   = nxt_irqStatus[`OSCRC_IRQ_FAIL_BIT] |
                                               (clockFailSync & ~clockFailFlag_ff);
        nxt_irqStatus[`OSCRC_IRQ_LOCK_BIT]   = nxt_irqStatus[`OSCRC_IRQ_LOCK_BIT] |
                                               (nxt_pllLocked & ~pllLockedFlag_ff);
        nxt_irqStatus[`OSCRC_IRQ_SWITCH_BIT] = nxt_irqStatus[`OSCRC_IRQ_SWITCH_BIT] |
                                               (oscSwitchRequest_ff & switchDonePulse);
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            irqStatus_ff <= `OSCRC_IRQ_RESET;
            irqMask_ff   <= `OSCRC_IRQ_RESET;
            irq_ff       <= 1'b0;
        end else begin
            irqStatus_ff <= nxt_irqStatus;
            if (wrMask) begin
                irqMask_ff <= regWrData[2:0];
            end
            irq_ff <= |(irqStatus_ff & irqMask_ff);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    assign oscControlView = {5'h00, nextOscSelect_ff, clockSelectLock_ff, 1'b0, pllLockedFlag_ff, 1'b0,
                             clockFailFlag_ff, secondaryOscHighDrive_ff, secondaryOscEnable_ff,
                             oscSwitchRequest_ff};

    always @* begin
        nxt_rdData = 16'h0000;
        if (!regRdStb) begin
            nxt_rdData = 16'h0000;
        end else if (is_addr(regAddr, `OSCRC_ADDR_OSC_CTRL)) begin
            nxt_rdData = oscControlView;
        end else if (is_addr(regAddr, `OSCRC_ADDR_REFCLK_CTRL)) begin
            nxt_rdData = refclkControl_ff;
        end else if (is_addr(regAddr, `OSCRC_ADDR_IRQ_STATUS)) begin
            nxt_rdData = {13'h0000, irqStatus_ff};
        end else if (is_addr(regAddr, `OSCRC_ADDR_IRQ_MASK)) begin
            nxt_rdData = {13'h0000, irqMask_ff};
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            regRdData_ff <= 16'h0000;
        end else begin
            regRdData_ff <= nxt_rdData;
        end
    end
endmodule // oscrc_top

//--- hw/oscrc_consts.vh
// Constants of the oscillator status and reference clock output block
`ifndef OSCRC_CONSTS_VH
`define OSCRC_CONSTS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OSCRC_ADDR_OSC_CTRL     4'h0
`define OSCRC_ADDR_REFCLK_CTRL  4'h1
`define OSCRC_ADDR_IRQ_STATUS   4'h2
`define OSCRC_ADDR_IRQ_MASK     4'h3
// ----------------------------------------------------------------
// Oscillator control fields
// ----------------------------------------------------------------
`define OSCRC_OSC_SWITCH_BIT    0
`define OSCRC_SECONDARY_OSCILLATOR_EN_BIT       1
`define OSCRC_SECONDARY_OSCILLATOR_DRV_BIT      2
`define OSCRC_CLK_FAIL_BIT      3
`define OSCRC_PLL_LOCK_BIT      5
`define OSCRC_CLK_LOCK_BIT      7
`define OSCRC_NEXT_OSC_LSB      8
`define OSCRC_NEXT_OSC_MSB      10
// ----------------------------------------------------------------
// Reference clock control fields
// ----------------------------------------------------------------
`define OSCRC_REF_DIV_LSB       8
`define OSCRC_REF_DIV_MSB       11
`define OSCRC_REF_SRC_BIT       12
`define OSCRC_REF_SLP_BIT       13
`define OSCRC_REF_EN_BIT        15
`define OSCRC_REFCLK_RESET      16'h0000
// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define OSCRC_IRQ_FAIL_BIT      0
`define OSCRC_IRQ_LOCK_BIT      1
`define OSCRC_IRQ_SWITCH_BIT    2
`define OSCRC_IRQ_RESET         3'h0
`endif

//--- hw/oscrc_sync.v
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module oscrc_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             reset_n,
    // Data
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule // oscrc_sync

//--- hw/oscrc_refdiv.v
// Power-of-two divider for the reference clock output
`timescale 1ns/10ps
module oscrc_refdiv (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       reset_n,
    // Control
    input  wire       runEn,
    input  wire       baseTick,
    input  wire [3:0] divSel,
    // Output
    output reg        refOut_ff
);
    reg [14:0] count_ff;
    reg        baseLevel_ff;
    reg        nxt_refOut;
    wire [15:0] stages;

    // Stage 0 is the base clock, stage k is base divided by 2^k
    assign stages = {count_ff, baseLevel_ff};

    always @(posedge ref_clk) begin
        if (!reset_n || !runEn) begin
            count_ff     <= 15'h0000;
            baseLevel_ff <= 1'b0;
        end else if (baseTick) begin
            baseLevel_ff <= ~baseLevel_ff;
            if (baseLevel_ff) begin
                count_ff <= count_ff + 15'h0001;
            end
        end
    end

    always @* begin
        nxt_refOut = runEn & stages[divSel];
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            refOut_ff <= 1'b0;
        end else begin
            refOut_ff <= nxt_refOut;
        end
    end
endmodule // oscrc_refdiv

//--- verification/oscrc_top_sva.sv
// Port assertions of the oscillator status and reference clock block
`timescale 1ns/10ps
module oscrc_top_sva (
    // Clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // Register port
    input wire [3:0]  regAddr,
    input wire        regWrStb,
    input wire        regRdStb,
    input wire [15:0] regRdData_ff,
    // Levels in
    input wire        secondaryOscSourceConfig,
    input wire        switchDone,
    // Outputs
    input wire        secondaryOscOn_ff,
    input wire        secondaryOscHighPower_ff,
    input wire        oscSwitchStart_ff,
    input wire [2:0]  nextOscSelect_ff,
    input wire        refclkOutputPin_ff,
    input wire        refclkOutputPinOe_ff,
    input wire        irq_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_reset_quiet_out: assert property (!$past(reset_n) |-> !irq_ff && !oscSwitchStart_ff && regRdData_ff == 16'h0)
        else $error("Outputs not quiet after reset");
    a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData_ff == 16'h0)
        else $error("Read data outside read cycle");
    a_drive_gated: assert property (secondaryOscHighPower_ff |-> $past(secondaryOscSourceConfig))
        else $error("High drive with digital clock input");
    a_osc_on_write: assert property ($changed(secondaryOscOn_ff) |-> $past(regWrStb, 2) && $past(regAddr, 2) == 4'h0)
        else $error("Oscillator enable moved without write");
    a_start_by_write: assert property ($rose(oscSwitchStart_ff) |-> $past(regWrStb, 2) && $past(regAddr, 2) == 4'h0)
        else $error("Switch start without write");
    a_start_by_done: assert property ($fell(oscSwitchStart_ff) |-> $past(switchDone, 2) || $past(switchDone, 4) || $past(switchDone, 6))
        else $error("Switch request cleared without completion");
    a_next_sel_src: assert property ($changed(nextOscSelect_ff) |-> $past(regWrStb) || !$past(reset_n, 2))
        else $error("Next oscillator changed without cause");
    a_pin_quiet_off: assert property (!refclkOutputPinOe_ff [*3] |-> !refclkOutputPin_ff)
        else $error("Reference pin active while disabled");
    a_oe_by_write: assert property ($changed(refclkOutputPinOe_ff) |-> $past(regWrStb) || $past(regWrStb, 2) || $past(regWrStb, 3))
        else $error("Output enable moved without write");
endmodule // oscrc_top_sva

bind oscrc_top oscrc_top_sva oscrc_top_sva_inst (.ref_clk, .reset_n, .regAddr, .regWrStb, .regRdStb, .regRdData_ff,
    .secondaryOscSourceConfig, .switchDone, .secondaryOscOn_ff, .secondaryOscHighPower_ff, .oscSwitchStart_ff,
    .nextOscSelect_ff, .refclkOutputPin_ff, .refclkOutputPinOe_ff, .irq_ff);

//--- verification/testbench.sv
// Self-checking bench of the oscillator status and reference clock block
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    reg          ref_clk = 1'b0;
    reg          reset_n = 1'b0;
    reg  [3:0]   regAddr = 4'h0;
    reg  [15:0]  regWrData = 16'h0;
    reg          regWrStb = 1'b0;
    reg          regRdStb = 1'b0;
    reg  [2:0]   initialOscConfig = 3'h0;
    reg          clockMonitorConfigBit = 1'b0;
    reg          secondaryOscSourceConfig = 1'b1;
    reg          primaryOscClk = 1'b0;
    reg          pllLockRaw = 1'b0;
    reg          pllTimerDone = 1'b0;
    reg          clockFailDetect = 1'b0;
    reg          switchDone = 1'b0;
    reg          sleepMode = 1'b0;
    reg          pllModeActive = 1'b0;
    reg          priRun = 1'b0;
    reg          rdPend = 1'b0;
    wire [15:0]  regRdData_ff;
    wire         secondaryOscOn_ff;
    wire         secondaryOscHighPower_ff;
    wire         oscSwitchStart_ff;
    wire [2:0]   nextOscSelect_ff;
    wire         refclkOutputPin_ff;
    wire         refclkOutputPinOe_ff;
    wire         irq_ff;
    logic [15:0] expQ[$];
    logic [15:0] tog;
    logic [31:0] seed = 32'h1;
    logic [31:0] r;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          i;
    int          n;

    oscrc_top oscrc_top_inst (.ref_clk, .reset_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData_ff,
        .initialOscConfig, .clockMonitorConfigBit, .secondaryOscSourceConfig, .primaryOscClk, .pllLockRaw,
        .pllTimerDone, .clockFailDetect, .switchDone, .sleepMode, .pllModeActive, .secondaryOscOn_ff,
        .secondaryOscHighPower_ff, .oscSwitchStart_ff, .nextOscSelect_ff, .refclkOutputPin_ff,
        .refclkOutputPinOe_ff, .irq_ff);

    always #50 ref_clk = ~ref_clk;
    // Odd half period keeps the primary edges off the bench clock
    always #373 if (priRun) primaryOscClk = ~primaryOscClk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Counts pin changes, seen as pre-edge values
    task automatic count_tog(input int c);
        logic p;
        tog = 16'h0;
        p = refclkOutputPin_ff;
        repeat (c) begin
            @(posedge ref_clk);
            if (refclkOutputPin_ff !== p) tog++;
            p = refclkOutputPin_ff;
        end
    endtask

    task end_sim();
        $display("Checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rdPend) chk("regRdData_ff", expQ.pop_front(), regRdData_ff);
        rdPend <= regRdStb;
    end

    initial begin
        #500000;
        bad_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        r = rnd();
        initialOscConfig = r[2:0];
        cyc(5);
        reset_n <= 1'b1;
        cyc(2);
        rd(4'h0, {5'h0, initialOscConfig, 8'h0});
        rd(4'h1, 16'h0);
        rd(4'h3, 16'h0);
        wr(4'h1, 16'hffff);
        rd(4'h1, 16'hbf00);
        wr(4'h0, 16'hff56);
        rd(4'h0, 16'h0706);
        chk("secondaryOscOn_ff", 16'h1, secondaryOscOn_ff);
        chk("secondaryOscHighPower_ff", 16'h1, secondaryOscHighPower_ff);
        secondaryOscSourceConfig <= 1'b0;
        cyc(2);
        chk("secondaryOscHighPower_ff", 16'h0, secondaryOscHighPower_ff);
        r = rnd();
        wr(4'h9, r[15:0]);
        rd(4'h9, 16'h0);
        clockMonitorConfigBit <= 1'b1;
        wr(4'h0, 16'h0386);
        wr(4'h0, 16'h0101);
        rd(4'h0, 16'h0300);
        wr(4'h0, 16'h0380);
        clockMonitorConfigBit <= 1'b0;
        wr(4'h0, 16'h0581);
        rd(4'h0, 16'h0581);
        chk("oscSwitchStart_ff", 16'h1, oscSwitchStart_ff);
        chk("nextOscSelect_ff", 16'h5, nextOscSelect_ff);
        switchDone <= 1'b1;
        n = 0;
        while (oscSwitchStart_ff !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        switchDone <= 1'b0;
        chk("oscSwitchStart_ff", 16'h0, oscSwitchStart_ff);
        rd(4'h0, 16'h0580);
        rd(4'h2, 16'h0004);
        chk("irq_ff", 16'h0, irq_ff);
        wr(4'h3, 16'h0004);
        cyc(2);
        chk("irq_ff", 16'h1, irq_ff);
        wr(4'h2, 16'h0004);
        cyc(2);
        chk("irq_ff", 16'h0, irq_ff);
        pllModeActive <= 1'b1;
        pllLockRaw <= 1'b1;
        clockFailDetect <= 1'b1;
        cyc(6);
        rd(4'h0, 16'h05a8);
        rd(4'h2, 16'h0003);
        chk("irq_ff", 16'h0, irq_ff);
        pllModeActive <= 1'b0;
        cyc(2);
        rd(4'h0, 16'h0588);
        // Start-up timer alone must raise the lock flag
        pllLockRaw <= 1'b0;
        pllTimerDone <= 1'b1;
        pllModeActive <= 1'b1;
        cyc(4);
        rd(4'h0, 16'h05a8);
        wr(4'h0, 16'h0581);
        rd(4'h0, 16'h0589);
        switchDone <= 1'b1;
        cyc(6);
        switchDone <= 1'b0;
        rd(4'h0, 16'h05a8);
        for (i = 0; i < 3; i++) begin
            n = (i == 2) ? 3 : i;
            wr(4'h1, {4'h8, n[3:0], 8'h0});
            cyc(8);
            count_tog(32);
            chk("refclk toggles", 16'h20 >> n, tog);
            chk("refclkOutputPinOe_ff", 16'h1, refclkOutputPinOe_ff);
        end
        sleepMode <= 1'b1;
        cyc(8);
        count_tog(32);
        chk("sleep toggles", 16'h0, tog);
        wr(4'h1, 16'ha300);
        cyc(8);
        count_tog(32);
        chk("sleep run toggles", 16'h4, tog);
        sleepMode <= 1'b0;
        wr(4'h1, 16'h9000);
        cyc(8);
        count_tog(32);
        chk("primary still", 16'h0, tog);
        priRun <= 1'b1;
        cyc(8);
        count_tog(32);
        chk("primary runs", 16'h1, {15'h0, tog != 16'h0});
        wr(4'h1, 16'h0);
        cyc(4);
        chk("refclkOutputPinOe_ff", 16'h0, refclkOutputPinOe_ff);
        chk("refclkOutputPin_ff", 16'h0, refclkOutputPin_ff);
        cyc(2);
        end_sim();
    end
endmodule // testbench
